// file: logic/jtpi_defs.vh
// Constants for the test access port pin interface
`ifndef JTPI_DEFS_VH
`define JTPI_DEFS_VH
`define JTPI_IR_W 4
`define JTPI_IR_CAPTURE 4'h1
`define JTPI_IR_IDCODE 4'h2
`define JTPI_IR_DEBUG 4'h7
`define JTPI_IR_BYPASS 4'hf
`define JTPI_IR_RESET 4'h2
`define JTPI_ID_W 32
// Arbitrary identity value, not tied to any real part
`define JTPI_ID_VALUE 32'h1234_5001
`define JTPI_DBG_W 8
`define JTPI_DBG_RESET 8'h00
// Sync reset values: tck, tms, tdi, trst_n, chip_rst_n
`define JTPI_SYNC_W 5
`define JTPI_SYNC_RESET 5'h06
`define JTPI_SB_TCK 0
`define JTPI_SB_TMS 1
`define JTPI_SB_TDI 2
`define JTPI_SB_TRST 3
`define JTPI_SB_CHIP 4
`endif

// file: logic/jtpi_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module jtpi_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input wire clk,
   input wire reset_n,
   input wire [WIDTH-1:0] d,
   output wire [WIDTH-1:0] q
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // First stage feeds only the second stage
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;
endmodule
`default_nettype wire

// file: logic/jtpi_top.v
// Test access port pin interface: TAP controller, TDO drive window, pull-ups
// Overview of operation
// - TMS is captured on each TCK rising edge and advances the state machine.
// - TDI is captured on each TCK rising edge in Shift-IR or Shift-DR.
// - TDO driven only in Shift-IR or Shift-DR, high impedance otherwise.
// - TDO changes only on TCK falling edges or when low TRST releases it, ready for host's next rising edge.
// - Low TRST resets the TAP controller regardless of TCK activity.
// - Chip reset alone leaves TAP and debug module state intact.
// - JTAG pull-up disable bit turns off TMS, TDI and TRST pull-ups.
`timescale 1ns/1ps
`default_nettype none
`include "jtpi_defs.vh"
module jtpi_top (
   input wire clk,
   input wire reset_n,
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire trst_n,
   input wire chip_rst_n,
   input wire pullup_disable_jtag,
   input wire [`JTPI_DBG_W-1:0] dbg_status,
   output reg tdo_o_r,
   output reg tdo_oe_n_r,
   output reg tms_pu_en_r,
   output reg tdi_pu_en_r,
   output reg trst_pu_en_r,
   output reg core_rst_n_r,
   output reg tap_reset_r,
   output reg [`JTPI_DBG_W-1:0] dbg_cmd_r,
   output reg dbg_cmd_valid_r
);
   // One-hot TAP states
   localparam [15:0] S_TLR = 16'h0001;
   localparam [15:0] S_RTI = 16'h0002;
   localparam [15:0] S_SDS = 16'h0004;
   localparam [15:0] S_CDR = 16'h0008;
   localparam [15:0] S_SHD = 16'h0010;
   localparam [15:0] S_E1D = 16'h0020;
   localparam [15:0] S_PSD = 16'h0040;
   localparam [15:0] S_E2D = 16'h0080;
   localparam [15:0] S_UDR = 16'h0100;
   localparam [15:0] S_SIS = 16'h0200;
   localparam [15:0] S_CIR = 16'h0400;
   localparam [15:0] S_SHI = 16'h0800;
   localparam [15:0] S_E1I = 16'h1000;
   localparam [15:0] S_PSI = 16'h2000;
   localparam [15:0] S_E2I = 16'h4000;
   localparam [15:0] S_UIR = 16'h8000;

   wire [`JTPI_SYNC_W-1:0] pin_s;
   wire tck_s;
   wire tms_s;
   wire tdi_s;
   wire trst_s;
   wire tck_rise;
   wire tck_fall;
   wire shifting;
   reg tck_d_r;
   reg [15:0] state_r;
   reg [15:0] state_nxt;
   reg [`JTPI_IR_W-1:0] ir_r;
   reg [`JTPI_IR_W-1:0] ir_sh_r;
   reg [`JTPI_ID_W-1:0] id_sh_r;
   reg [`JTPI_DBG_W-1:0] dbg_sh_r;
   reg byp_r;
   reg dr_out;

   // All pins, including the link clock, pass two flops before use
   jtpi_sync #(
      .WIDTH(`JTPI_SYNC_W),
      .RST_VAL(`JTPI_SYNC_RESET)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({chip_rst_n, trst_n, tdi, tms, tck}),
      .q(pin_s)
   );

   assign tck_s = pin_s[`JTPI_SB_TCK];
   assign tms_s = pin_s[`JTPI_SB_TMS];
   assign tdi_s = pin_s[`JTPI_SB_TDI];
   assign trst_s = pin_s[`JTPI_SB_TRST];

   // Edge finder on the synchronised TCK; TMS/TDI share its latency
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tck_d_r <= 1'b0;
      end else begin
         tck_d_r <= tck_s;
      end
   end

   assign tck_rise = tck_s & ~tck_d_r;
   assign tck_fall = ~tck_s & tck_d_r;
   assign shifting = (state_r == S_SHI) || (state_r == S_SHD);

   // Next-state table of the TAP controller
   always @* begin
      case (state_r)
         S_TLR: state_nxt = tms_s ? S_TLR : S_RTI;
         S_RTI: state_nxt = tms_s ? S_SDS : S_RTI;
         S_SDS: state_nxt = tms_s ? S_SIS : S_CDR;
         S_CDR: state_nxt = tms_s ? S_E1D : S_SHD;
         S_SHD: state_nxt = tms_s ? S_E1D : S_SHD;
         S_E1D: state_nxt = tms_s ? S_UDR : S_PSD;
         S_PSD: state_nxt = tms_s ? S_E2D : S_PSD;
         S_E2D: state_nxt = tms_s ? S_UDR : S_SHD;
         S_UDR: state_nxt = tms_s ? S_SDS : S_RTI;
         S_SIS: state_nxt = tms_s ? S_TLR : S_CIR;
         S_CIR: state_nxt = tms_s ? S_E1I : S_SHI;
         S_SHI: state_nxt = tms_s ? S_E1I : S_SHI;
         S_E1I: state_nxt = tms_s ? S_UIR : S_PSI;
         S_PSI: state_nxt = tms_s ? S_E2I : S_PSI;
         S_E2I: state_nxt = tms_s ? S_UIR : S_SHI;
         S_UIR: state_nxt = tms_s ? S_SDS : S_RTI;
         default: state_nxt = S_TLR;
      endcase
   end

   // Serial bit presented by the selected data register
   always @* begin
      case (ir_r)
         `JTPI_IR_IDCODE: dr_out = id_sh_r[0];
         `JTPI_IR_DEBUG: dr_out = dbg_sh_r[0];
         default: dr_out = byp_r;
      endcase
   end

   // TAP state and scan registers; chip reset is deliberately not a term here
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= S_TLR;
         ir_r <= `JTPI_IR_RESET;
         ir_sh_r <= `JTPI_IR_CAPTURE;
         id_sh_r <= `JTPI_ID_VALUE;
         dbg_sh_r <= `JTPI_DBG_RESET;
         byp_r <= 1'b0;
         dbg_cmd_r <= `JTPI_DBG_RESET;
         dbg_cmd_valid_r <= 1'b0;
         tap_reset_r <= 1'b1;
      end else if (!trst_s) begin
         // Acts with TCK stopped too, since it uses only clk
         state_r <= S_TLR;
         ir_r <= `JTPI_IR_RESET;
         dbg_cmd_r <= `JTPI_DBG_RESET;
         dbg_cmd_valid_r <= 1'b0;
         tap_reset_r <= 1'b1;
      end else begin
         dbg_cmd_valid_r <= 1'b0;
         tap_reset_r <= (state_r == S_TLR);
         if (tck_rise) begin
            state_r <= state_nxt;
            case (state_r)
               S_TLR: begin
                  ir_r <= `JTPI_IR_RESET;
               end
               S_CIR: begin
                  ir_sh_r <= `JTPI_IR_CAPTURE;
               end
               S_SHI: begin
                  ir_sh_r <= {tdi_s, ir_sh_r[`JTPI_IR_W-1:1]};
               end
               S_UIR: begin
                  ir_r <= ir_sh_r;
               end
               S_CDR: begin
                  id_sh_r <= `JTPI_ID_VALUE;
                  dbg_sh_r <= dbg_status;
                  byp_r <= 1'b0;
               end
               S_SHD: begin
                  // Only the register that the instruction selects moves
                  case (ir_r)
                     `JTPI_IR_IDCODE: id_sh_r <= {tdi_s, id_sh_r[`JTPI_ID_W-1:1]};
                     `JTPI_IR_DEBUG: dbg_sh_r <= {tdi_s, dbg_sh_r[`JTPI_DBG_W-1:1]};
                     default: byp_r <= tdi_s;
                  endcase
               end
               S_UDR: begin
                  if (ir_r == `JTPI_IR_DEBUG) begin
                     dbg_cmd_r <= dbg_sh_r;
                     dbg_cmd_valid_r <= 1'b1;
                  end
               end
               default: begin
                  ir_r <= ir_r;
               end
            endcase
         end
      end
   end

   // TDO moves only on the falling edge so the host samples it stable, or is released at once by low TRST
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tdo_o_r <= 1'b0;
         tdo_oe_n_r <= 1'b1;
      end else if (!trst_s) begin
         tdo_oe_n_r <= 1'b1;
      end else if (tck_fall) begin
         tdo_o_r <= (state_r == S_SHI) ? ir_sh_r[0] : dr_out;
         tdo_oe_n_r <= ~shifting;
      end
   end

   // Pull-up control and the core reset, which never reaches the TAP
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tms_pu_en_r <= 1'b1;
         tdi_pu_en_r <= 1'b1;
         trst_pu_en_r <= 1'b1;
         core_rst_n_r <= 1'b0;
      end else begin
         tms_pu_en_r <= ~pullup_disable_jtag;
         tdi_pu_en_r <= ~pullup_disable_jtag;
         trst_pu_en_r <= ~pullup_disable_jtag;
         core_rst_n_r <= pin_s[`JTPI_SB_CHIP];
      end
   end
endmodule
`default_nettype wire

// file: testbench/jtpi_host.sv
// Host model driving the TAP pins
`timescale 1ns/1ps
`default_nettype none
module jtpi_host (
   input wire clk,
   input wire tdo,
   output var logic tck,
   output var logic tms,
   output var logic tdi
);
   // Test clock rests low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // One 160 ns TCK period; TMS and TDI settle while TCK is low
   task automatic bit_x(input logic m, input logic d, output logic q);
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clk);
      tck <= 1'b1;
      q = tdo; // Taken at the rise, as the device expects
      repeat (4) @(posedge clk);
      tck <= 1'b0;
   endtask
endmodule
`default_nettype wire

// file: testbench/jtpi_monitor.sv
// Checker for the TAP pin interface ports
`timescale 1ns/1ps
`default_nettype none
`include "jtpi_defs.vh"
module jtpi_monitor (
   input wire clk,
   input wire reset_n,
   input wire tck,
   input wire trst_n,
   input wire chip_rst_n,
   input wire pullup_disable_jtag,
   input wire tdo_o_r,
   input wire tdo_oe_n_r,
   input wire tms_pu_en_r,
   input wire tdi_pu_en_r,
   input wire trst_pu_en_r,
   input wire core_rst_n_r,
   input wire tap_reset_r,
   input wire [`JTPI_DBG_W-1:0] dbg_cmd_r,
   input wire dbg_cmd_valid_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_trst_enter: assert property ($fell(trst_n) |-> ##[1:4] tap_reset_r)
      else $error("tap not reset by trst");
   chk_trst_hold: assert property (!trst_n [*4] |-> tap_reset_r)
      else $error("tap left reset while trst low");
   chk_reset_hiz: assert property (tap_reset_r |-> tdo_oe_n_r)
      else $error("tdo driven in reset state");
   chk_pullup_follow: assert property ($changed(pullup_disable_jtag) |=>
      {tms_pu_en_r, tdi_pu_en_r, trst_pu_en_r} == {3{!$past(pullup_disable_jtag)}})
      else $error("pull-ups do not follow disable bit");
   chk_chip_path: assert property ($changed(chip_rst_n) |->
      ##[2:3] core_rst_n_r == chip_rst_n)
      else $error("core reset does not follow chip reset");
   chk_chip_keep: assert property ($fell(core_rst_n_r) |->
      $stable(tap_reset_r) && $stable(dbg_cmd_r))
      else $error("chip reset disturbed tap");
   // Only a driven TDO is judged; the released pin may settle freely
   chk_tdo_fall: assert property (
      $changed(tdo_oe_n_r) || ($changed(tdo_o_r) && !tdo_oe_n_r)
      |-> !$past(tck, 2) && ($past(tck, 3) || $past(tck, 4)))
      else $error("tdo changed away from tck fall");
   chk_cmd_rise: assert property (dbg_cmd_valid_r |-> $past(tck, 2) &&
      (!$past(tck, 3) || !$past(tck, 4)) ##1 !dbg_cmd_valid_r)
      else $error("debug command pulse misplaced");
endmodule
bind jtpi_top jtpi_monitor u_mon (.clk(clk), .reset_n(reset_n), .tck(tck), .trst_n(trst_n),
   .chip_rst_n(chip_rst_n), .pullup_disable_jtag(pullup_disable_jtag), .tdo_o_r(tdo_o_r),
   .tdo_oe_n_r(tdo_oe_n_r), .tms_pu_en_r(tms_pu_en_r), .tdi_pu_en_r(tdi_pu_en_r),
   .trst_pu_en_r(trst_pu_en_r), .core_rst_n_r(core_rst_n_r), .tap_reset_r(tap_reset_r),
   .dbg_cmd_r(dbg_cmd_r), .dbg_cmd_valid_r(dbg_cmd_valid_r));
`default_nettype wire

// file: testbench/jtpi_top_tb_top.sv
// Testbench for the TAP pin interface
`timescale 1ns/1ps
`default_nettype none
`include "jtpi_defs.vh"
module jtpi_top_tb_top;
   logic clk, reset_n, trst_n, chip_rst_n, pud;
   logic [`JTPI_DBG_W-1:0] dstat;
   logic [31:0] d;
   wire tck, tms, tdi, tdo_o, oe_n, tpu, dpu, rpu, core_n, tap_rst, cval;
   wire [`JTPI_DBG_W-1:0] cmd;
   wire tdo_pin = oe_n ? 1'bz : tdo_o; // Nothing pulls TDO, so released reads z
   int failures, num_checks;
   jtpi_top u_dut (.clk(clk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi),
      .trst_n(trst_n), .chip_rst_n(chip_rst_n), .pullup_disable_jtag(pud), .dbg_status(dstat),
      .tdo_o_r(tdo_o), .tdo_oe_n_r(oe_n), .tms_pu_en_r(tpu), .tdi_pu_en_r(dpu),
      .trst_pu_en_r(rpu), .core_rst_n_r(core_n), .tap_reset_r(tap_rst), .dbg_cmd_r(cmd),
      .dbg_cmd_valid_r(cval));
   jtpi_host u_host (.clk(clk), .tdo(tdo_pin), .tck(tck), .tms(tms), .tdi(tdi));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Walk the state machine with a TMS sequence, LSB first
   task automatic path(input logic [7:0] seq, input int n);
      logic q;
      for (int i = 0; i < n; i++) u_host.bit_x(seq[i], 1'b0, q);
   endtask
   // Shift n bits LSB first; TMS rises on the last to leave the shift state
   task automatic scan(input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      for (int i = 0; i < n; i++) begin
         u_host.bit_x(i == n - 1, din[i], q);
         dout[i] = q;
      end
   endtask
   task automatic t_pullups;
      pud <= 1'b1;
      repeat (3) @(posedge clk);
      chk({tpu, dpu, rpu}, 3'b000);
      pud <= 1'b0;
      repeat (3) @(posedge clk);
      chk({tpu, dpu, rpu}, 3'b111);
   endtask
   task automatic t_idcode;
      chk(tdo_pin, 1'bz);
      path(8'h02, 4);
      scan(32, 32'h0, d);
      chk(d, `JTPI_ID_VALUE);
      path(8'h01, 2);
      repeat (4) @(posedge clk);
      chk(oe_n, 1'b1);
   endtask
   task automatic t_debug;
      path(8'h03, 4);
      scan(4, `JTPI_IR_DEBUG, d);
      chk(d[3:0], `JTPI_IR_CAPTURE);
      dstat <= 8'h3c;
      path(8'h05, 5);
      scan(8, 32'ha5, d);
      chk(d[7:0], 8'h3c);
      path(8'h01, 2);
      chk(cmd, 8'ha5);
   endtask
   // Bypass captures zero, so every bit comes back one TCK later
   task automatic t_bypass;
      path(8'h03, 4);
      scan(4, `JTPI_IR_BYPASS, d);
      chk(d[3:0], `JTPI_IR_CAPTURE);
      path(8'h05, 5);
      scan(8, 32'h96, d);
      chk(d[7:0], 8'h2c);
      path(8'h01, 2);
   endtask
   task automatic t_resets;
      chip_rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk({core_n, tap_rst, cmd}, {2'b00, 8'ha5});
      trst_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk({core_n, tap_rst, cmd}, {2'b01, 8'h00});
      chip_rst_n <= 1'b1;
      trst_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk(core_n, 1'b1);
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Hang guard
   initial begin
      #100us;
      failures++;
      give_verdict();
   end
   initial begin
      reset_n = 1'b0;
      trst_n = 1'b0;
      chip_rst_n = 1'b0;
      pud = 1'b0;
      dstat = 8'h00;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      trst_n <= 1'b1;
      chip_rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_pullups();
      t_idcode();
      t_debug();
      t_bypass();
      t_resets();
      give_verdict();
   end
endmodule
`default_nettype wire
